/* File: cmsc_core.sv */
// Purpose: operating mode, instruction state and exception entry control
// Assumes: pipeline events are one-cycle pulses on hclk; irq/fiq are async levels
// Notes: registers reached over AHB-Lite, zero wait states, always OKAY
`timescale 1ns/1ps
module cmsc_core
  import cmsc_pkg::*;
(
  input wire logic hclk, // core clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // slave response
  output logic [31:0] hrdata, // read data
  input wire logic irq_req, // normal interrupt request level
  input wire logic fiq_req, // fast interrupt request level
  input wire cmsc_events_t events, // pipeline event pulses
  input wire logic [31:0] exec_pc, // address of the current instruction
  input wire logic sp_wr_en, // pipeline writes current stack pointer
  input wire logic [31:0] sp_wr_data, // new stack pointer value
  output logic [4:0] cur_mode, // current mode field
  output logic compact_state, // 16-bit instruction state
  output logic privileged, // not application mode
  output logic [31:0] active_sp, // stack pointer of current mode
  output cmsc_redirect_t vector_out, // exception entry fetch redirect
  output cmsc_redirect_t resume_out // return-to-interrupted-code redirect
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [MODE_IDX_W-1:0] mode_idx(input logic [4:0] m);
    case (m)
      MODE_APPLICATION: mode_idx = 3'h0;
      MODE_FAST_INTERRUPT: mode_idx = 3'h1;
      MODE_NORMAL_INTERRUPT: mode_idx = 3'h2;
      MODE_SUPERVISOR: mode_idx = 3'h3;
      MODE_ABORT: mode_idx = 3'h4;
      MODE_UNDEFINED_INSTRUCTION: mode_idx = 3'h5;
      MODE_SYSTEM: mode_idx = 3'h6;
      default: mode_idx = 3'h0;
    endcase
  endfunction : mode_idx

  function automatic logic mode_legal(input logic [4:0] m);
    case (m)
      MODE_APPLICATION, MODE_FAST_INTERRUPT, MODE_NORMAL_INTERRUPT, MODE_SUPERVISOR,
      MODE_ABORT, MODE_UNDEFINED_INSTRUCTION, MODE_SYSTEM: mode_legal = 1'b1;
      default: mode_legal = 1'b0;
    endcase
  endfunction : mode_legal

  function automatic logic has_saved(input logic [4:0] m);
    // application and system modes are not exception modes
    has_saved = (m != MODE_APPLICATION) && (m != MODE_SYSTEM);
  endfunction : has_saved

  function automatic logic [31:0] pack_status(input cmsc_status_t s);
    pack_status = 32'h0000_0000;
    pack_status[FLAGS_MSB:FLAGS_LSB] = s.flags;
    pack_status[IRQ_OFF_BIT] = s.irq_off;
    pack_status[FIQ_OFF_BIT] = s.fiq_off;
    pack_status[COMPACT_BIT] = s.compact;
    pack_status[MODE_MSB:MODE_LSB] = s.mode;
  endfunction : pack_status

  function automatic cmsc_status_t unpack_status(input logic [31:0] w);
    unpack_status.flags = w[FLAGS_MSB:FLAGS_LSB];
    unpack_status.irq_off = w[IRQ_OFF_BIT];
    unpack_status.fiq_off = w[FIQ_OFF_BIT];
    unpack_status.compact = w[COMPACT_BIT];
    unpack_status.mode = w[MODE_MSB:MODE_LSB];
  endfunction : unpack_status

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cmsc_status_t status;
  cmsc_status_t saved_status [NUM_MODES];
  logic [31:0] saved_ret [NUM_MODES];
  logic [31:0] sp_bank [NUM_MODES];
  logic [31:0] last_vector;
  logic irq_meta, irq_sync, fiq_meta, fiq_sync;
  logic wr_pend;
  logic [ADDR_W-1:0] wr_addr;
  logic [ADDR_W-1:0] rd_addr;
  cmsc_exc_t exc;
  logic [MODE_IDX_W-1:0] cur_idx;
  logic is_priv;

  assign cur_idx = mode_idx(status.mode);
  assign is_priv = (status.mode != MODE_APPLICATION);

  // ----------------------------------------------------------------
  // interrupt request synchronisers
  // ----------------------------------------------------------------
  // requests are levels held by the controller, so sampling late is safe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_meta <= 1'b0;
      irq_sync <= 1'b0;
      fiq_meta <= 1'b0;
      fiq_sync <= 1'b0;
    end else begin
      irq_meta <= irq_req;
      irq_sync <= irq_meta;
      fiq_meta <= fiq_req;
      fiq_sync <= fiq_meta;
    end
  end

  // ----------------------------------------------------------------
  // exception arbitration
  // ----------------------------------------------------------------
  cmsc_prio u_prio (
    .data_abort (events.data_abort),
    .fiq_take (fiq_sync & ~status.fiq_off),
    .irq_take (irq_sync & ~status.irq_off),
    .fetch_abort (events.fetch_abort),
    .undef (events.undef),
    .trap (events.trap),
    .exc (exc)
  );

  logic [4:0] entry_mode;
  logic [31:0] entry_vec;
  logic entry;

  always_comb begin
    entry = 1'b1;
    unique case (exc)
      EXC_DATA_ABORT: begin
        entry_mode = MODE_ABORT;
        entry_vec = VEC_DATA_ABORT;
      end
      EXC_FIQ: begin
        entry_mode = MODE_FAST_INTERRUPT;
        entry_vec = VEC_FIQ;
      end
      EXC_IRQ: begin
        entry_mode = MODE_NORMAL_INTERRUPT;
        entry_vec = VEC_IRQ;
      end
      EXC_FETCH_ABORT: begin
        entry_mode = MODE_ABORT;
        entry_vec = VEC_FETCH_ABORT;
      end
      EXC_UNDEF: begin
        entry_mode = MODE_UNDEFINED_INSTRUCTION;
        entry_vec = VEC_UNDEF;
      end
      EXC_TRAP: begin
        entry_mode = MODE_SUPERVISOR;
        entry_vec = VEC_TRAP;
      end
      default: begin
        entry = 1'b0;
        entry_mode = status.mode;
        entry_vec = VEC_RESET;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // bus slave: address phase capture
  // ----------------------------------------------------------------
  logic addr_phase;
  assign addr_phase = hsel & hready & htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else if (hready) begin
      wr_pend <= addr_phase & hwrite;
      wr_addr <= haddr[ADDR_W-1:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // write strobes, decoded in the data phase
  logic wr_status, wr_sp_cur, wr_cmd, wr_bank;
  logic [MODE_IDX_W-1:0] bank_idx;
  logic do_return;
  assign wr_status = wr_pend && (wr_addr == REG_STATUS);
  assign wr_sp_cur = wr_pend && (wr_addr == REG_STACK_PTR);
  assign wr_cmd = wr_pend && (wr_addr == REG_COMMAND);
  assign wr_bank = wr_pend && is_priv && (wr_addr >= REG_SP_BANK)
                   && (wr_addr <= REG_SP_BANK_END) && (wr_addr[1:0] == 2'b00);
  assign bank_idx = MODE_IDX_W'((wr_addr - REG_SP_BANK) >> 2);
  // resume only makes sense from a mode that holds a saved context
  assign do_return = wr_cmd && hwdata[CMD_RETURN_BIT] && has_saved(status.mode);

  // ----------------------------------------------------------------
  // status word: mode, masks, compact state, flags
  // ----------------------------------------------------------------
  cmsc_status_t wr_st;
  assign wr_st = unpack_status(hwdata);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // reset entry: supervisor, both masks set, 32-bit state
      status.flags <= FLAGS_RESET;
      status.irq_off <= 1'b1;
      status.fiq_off <= 1'b1;
      status.compact <= 1'b0;
      status.mode <= MODE_SUPERVISOR;
    end else if (entry) begin
      // an exception outranks any same-cycle software write
      status.mode <= entry_mode;
      status.irq_off <= 1'b1;
      if (exc == EXC_FIQ) begin
        status.fiq_off <= 1'b1;
      end
    end else if (do_return) begin
      status <= saved_status[cur_idx];
    end else if (events.branch_and_exchange) begin
      status.compact <= events.bx_target_compact;
    end else if (wr_status) begin
      status.flags <= wr_st.flags;
      // application code may only touch the condition flags
      if (is_priv) begin
        status.irq_off <= wr_st.irq_off;
        status.fiq_off <= wr_st.fiq_off;
        if (mode_legal(wr_st.mode)) begin
          status.mode <= wr_st.mode;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // saved context per exception mode
  // ----------------------------------------------------------------
  logic [MODE_IDX_W-1:0] entry_idx;
  assign entry_idx = mode_idx(entry_mode);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_MODES; i++) begin
        saved_status[i] <= '0;
        saved_ret[i] <= '0;
      end
    end else if (entry) begin
      saved_status[entry_idx] <= status;
      saved_ret[entry_idx] <= exec_pc;
    end
  end

  // ----------------------------------------------------------------
  // banked stack pointers
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_MODES; g++) begin : g_sp
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sp_bank[g] <= SP_RESET;
        end else if (!entry && sp_wr_en && (cur_idx == MODE_IDX_W'(g))) begin
          sp_bank[g] <= sp_wr_data;
        end else if (wr_sp_cur && (cur_idx == MODE_IDX_W'(g))) begin
          sp_bank[g] <= hwdata;
        end else if (wr_bank && (bank_idx == MODE_IDX_W'(g))) begin
          sp_bank[g] <= hwdata;
        end
      end
    end
  endgenerate

  // selection follows the mode field, so entry switches stacks at once
  assign active_sp = sp_bank[cur_idx];

  // ----------------------------------------------------------------
  // redirect outputs
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vector_out <= '0;
      resume_out <= '0;
      last_vector <= VEC_RESET;
    end else begin
      vector_out.valid <= entry;
      vector_out.addr <= VECTOR_BASE + entry_vec;
      resume_out.valid <= do_return && !entry;
      resume_out.addr <= saved_ret[cur_idx];
      if (entry) begin
        last_vector <= entry_vec;
      end
    end
  end

  assign cur_mode = status.mode;
  assign compact_state = status.compact;
  assign privileged = is_priv;

  // ----------------------------------------------------------------
  // bus slave: read data
  // ----------------------------------------------------------------
  // captured in the address phase so read data leaves a flop; no read has side effects
  logic [MODE_IDX_W-1:0] rd_bank_idx;
  assign rd_addr = haddr[ADDR_W-1:0];
  assign rd_bank_idx = MODE_IDX_W'((rd_addr - REG_SP_BANK) >> 2);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready) begin
      hrdata <= 32'h0000_0000;
      if (addr_phase && !hwrite) begin
        if (rd_addr == REG_STATUS) begin
          hrdata <= pack_status(status);
        end else if (rd_addr == REG_SAVED_STATUS) begin
          hrdata <= pack_status(saved_status[cur_idx]);
        end else if (rd_addr == REG_RETURN_ADDR) begin
          hrdata <= saved_ret[cur_idx];
        end else if (rd_addr == REG_STACK_PTR) begin
          hrdata <= sp_bank[cur_idx];
        end else if (rd_addr == REG_LAST_VECTOR) begin
          hrdata <= last_vector;
        end else if ((rd_addr >= REG_SP_BANK) && (rd_addr <= REG_SP_BANK_END)
                     && (rd_addr[1:0] == 2'b00) && is_priv) begin
          hrdata <= sp_bank[rd_bank_idx];
        end
      end
    end
  end

  // hsize is accepted as a whole word; narrower writes update the full word
  logic unused_ok;
  assign unused_ok = &{1'b0, hsize, haddr[31:ADDR_W]};

endmodule : cmsc_core

/* File: cmsc_pkg.sv */
// Purpose: shared constants and types for the cpu mode and state control block
// Assumes: one core clock, asynchronous active-low reset
// Notes: register map sits on an AHB-Lite slave, one 32-bit word per register
package cmsc_pkg;

  // ----------------------------------------------------------------
  // operating modes and status word layout
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    MODE_APPLICATION = 5'h10,
    MODE_FAST_INTERRUPT = 5'h11,
    MODE_NORMAL_INTERRUPT = 5'h12,
    MODE_SUPERVISOR = 5'h13,
    MODE_ABORT = 5'h17,
    MODE_UNDEFINED_INSTRUCTION = 5'h1B,
    MODE_SYSTEM = 5'h1F
  } cmsc_mode_t;

  localparam int NUM_MODES = 7;
  localparam int MODE_IDX_W = 3;
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 4;
  localparam int COMPACT_BIT = 5;
  localparam int FIQ_OFF_BIT = 6;
  localparam int IRQ_OFF_BIT = 7;
  localparam int FLAGS_LSB = 28;
  localparam int FLAGS_MSB = 31;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

  // ----------------------------------------------------------------
  // exception kinds and vector offsets
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    EXC_NONE = 3'h0,
    EXC_DATA_ABORT = 3'h1,
    EXC_FIQ = 3'h2,
    EXC_IRQ = 3'h3,
    EXC_FETCH_ABORT = 3'h4,
    EXC_UNDEF = 3'h5,
    EXC_TRAP = 3'h6
  } cmsc_exc_t;

  localparam logic [31:0] VECTOR_BASE = 32'h0000_0000;
  localparam logic [31:0] VEC_RESET = 32'h0000_0000;
  localparam logic [31:0] VEC_UNDEF = 32'h0000_0004;
  localparam logic [31:0] VEC_TRAP = 32'h0000_0008;
  localparam logic [31:0] VEC_FETCH_ABORT = 32'h0000_000C;
  localparam logic [31:0] VEC_DATA_ABORT = 32'h0000_0010;
  localparam logic [31:0] VEC_IRQ = 32'h0000_0018;
  localparam logic [31:0] VEC_FIQ = 32'h0000_001C;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_SAVED_STATUS = 8'h04;
  localparam logic [7:0] REG_RETURN_ADDR = 8'h08;
  localparam logic [7:0] REG_STACK_PTR = 8'h0C;
  localparam logic [7:0] REG_COMMAND = 8'h10;
  localparam logic [7:0] REG_LAST_VECTOR = 8'h14;
  localparam logic [7:0] REG_SP_BANK = 8'h20;
  localparam logic [7:0] REG_SP_BANK_END = 8'h38;
  localparam int CMD_RETURN_BIT = 0;
  localparam int ADDR_W = 8;
  localparam logic [31:0] SP_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic trap;
    logic undef;
    logic fetch_abort;
    logic data_abort;
    logic branch_and_exchange;
    logic bx_target_compact;
  } cmsc_events_t;

  typedef struct packed {
    logic [3:0] flags;
    logic irq_off;
    logic fiq_off;
    logic compact;
    logic [4:0] mode;
  } cmsc_status_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } cmsc_redirect_t;

endpackage : cmsc_pkg

/* File: cmsc_prio.sv */
// Purpose: pick the one exception to take among those pending
// Assumes: fiq_take and irq_take already qualified by the interrupt disable flags
// Notes: purely combinational
`timescale 1ns/1ps
module cmsc_prio
  import cmsc_pkg::*;
(
  input wire logic data_abort, // data access aborted
  input wire logic fiq_take, // fast request, unmasked
  input wire logic irq_take, // normal request, unmasked
  input wire logic fetch_abort, // instruction fetch aborted
  input wire logic undef, // undefined encoding executed
  input wire logic trap, // software trap executed
  output cmsc_exc_t exc // winning exception
);

  always_comb begin
    if (data_abort) begin
      exc = EXC_DATA_ABORT;
    end else if (fiq_take) begin
      exc = EXC_FIQ;
    end else if (irq_take) begin
      exc = EXC_IRQ;
    end else if (fetch_abort) begin
      exc = EXC_FETCH_ABORT;
    end else if (undef) begin
      // equal rank; one instruction cannot be both, undef checked first
      exc = EXC_UNDEF;
    end else if (trap) begin
      exc = EXC_TRAP;
    end else begin
      exc = EXC_NONE;
    end
  end

endmodule : cmsc_prio

/* File: cmsc_chk.sv */
// Purpose: port-level checker for cmsc_core
// Assumes: single clock, asynchronous active-low reset
// Notes: bound to cmsc_core at the foot of this file
`timescale 1ns/1ps
module cmsc_chk
  import cmsc_pkg::*;
(
  input wire logic hclk, // core clock
  input wire logic hresetn, // reset, active low
  input wire logic irq_req, // normal request level
  input wire logic fiq_req, // fast request level
  input wire cmsc_events_t events, // event pulses
  input wire logic [4:0] cur_mode, // mode field
  input wire logic compact_state, // 16-bit state
  input wire logic privileged, // privileged mode
  input wire cmsc_redirect_t vector_out, // entry redirect
  input wire cmsc_redirect_t resume_out // return redirect
);
  logic [2:0] ih;
  logic [2:0] fh;
  logic quiet;
  logic hi;
  // ------------------------------------------------------------
  // request history
  // ------------------------------------------------------------
  // a level seen lately may still be crossing the synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ih <= 3'h0;
      fh <= 3'h0;
    end else begin
      ih <= {ih[1:0], irq_req};
      fh <= {fh[1:0], fiq_req};
    end
  end
  assign quiet = ~|{ih, fh, irq_req, fiq_req};
  assign hi = events.data_abort | events.fetch_abort;
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_priv;
    privileged == (cur_mode != 5'h10);
  endproperty
  a_priv: assert property (p_priv) else $error("privilege flag wrong");
  property p_trap;
    events.trap && !events.undef && !hi && quiet |=>
      cur_mode == 5'h13 && vector_out.valid && vector_out.addr == 32'h0000_0008;
  endproperty
  a_trap: assert property (p_trap) else $error("trap entry wrong");
  property p_undef;
    events.undef && !hi && quiet |=> cur_mode == 5'h1B;
  endproperty
  a_undef: assert property (p_undef) else $error("undefined entry wrong");
  property p_dabort;
    events.data_abort |=> cur_mode == 5'h17 && vector_out.addr == 32'h0000_0010;
  endproperty
  a_dabort: assert property (p_dabort) else $error("data abort entry wrong");
  property p_fabort;
    events.fetch_abort && !events.data_abort && quiet |=>
      cur_mode == 5'h17 && vector_out.addr == 32'h0000_000C;
  endproperty
  a_fabort: assert property (p_fabort) else $error("fetch abort entry wrong");
  property p_irq;
    vector_out.valid && vector_out.addr == 32'h0000_0018 |-> cur_mode == 5'h12;
  endproperty
  a_irq: assert property (p_irq) else $error("normal entry mode wrong");
  property p_fiq;
    vector_out.valid && vector_out.addr == 32'h0000_001C |-> cur_mode == 5'h11;
  endproperty
  a_fiq: assert property (p_fiq) else $error("fast entry mode wrong");
  property p_state;
    !$stable(compact_state) |-> $past(events.branch_and_exchange) || resume_out.valid;
  endproperty
  a_state: assert property (p_state) else $error("state changed without cause");
  property p_bx;
    events.branch_and_exchange && !events.trap && !events.undef && !hi && quiet |=>
      resume_out.valid || compact_state == $past(events.bx_target_compact);
  endproperty
  a_bx: assert property (p_bx) else $error("exchange target not taken");
  property p_app;
    $past(cur_mode) == 5'h10 && cur_mode != 5'h10 |-> vector_out.valid;
  endproperty
  a_app: assert property (p_app) else $error("left application mode directly");
  c_irq: cover property (vector_out.valid && vector_out.addr == 32'h0000_0018);
  c_fiq: cover property (vector_out.valid && vector_out.addr == 32'h0000_001C);
  c_bx: cover property (events.branch_and_exchange ##1 compact_state);
endmodule : cmsc_chk

bind cmsc_core cmsc_chk u_chk (.hclk(hclk), .hresetn(hresetn), .irq_req(irq_req),
  .fiq_req(fiq_req), .events(events), .cur_mode(cur_mode), .compact_state(compact_state),
  .privileged(privileged), .vector_out(vector_out), .resume_out(resume_out));

/* File: cmsc_partner.sv */
// Purpose: interrupt controller and memory system model
// Assumes: commands from the bench arrive as one-cycle pulses
// Notes: request levels stay up until the source is cleared
`timescale 1ns/1ps
module cmsc_partner
  import cmsc_pkg::*;
(
  input wire logic hclk, // core clock
  input wire logic hresetn, // reset, active low
  input wire logic [1:0] raise, // bit1 fast, bit0 normal source fires
  input wire logic [1:0] clear, // software cleared that source
  input wire cmsc_events_t ev_cmd, // event to report
  output logic irq_req, // normal request level
  output logic fiq_req, // fast request level
  output cmsc_events_t events // event pulses to the core
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_req <= 1'b0;
      fiq_req <= 1'b0;
      events <= '0;
    end else begin
      irq_req <= raise[0] | (irq_req & ~clear[0]);
      fiq_req <= raise[1] | (fiq_req & ~clear[1]);
      events <= ev_cmd;
    end
  end
endmodule : cmsc_partner

/* File: cmsc_tb_top.sv */
// Purpose: self-checking bench for cmsc_core
// Assumes: zero wait state slave, reads checked by a monitor queue
// Notes: partner model raises interrupts and events
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module cmsc_tb_top import cmsc_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, sp_wr_en, rd_dp;
  logic irq_req, fiq_req, compact_state, privileged;
  logic [1:0] htrans, raise, clear;
  logic [2:0] hsize;
  logic [4:0] cur_mode;
  logic [31:0] haddr, hwdata, hrdata, exec_pc, sp_wr_data, active_sp, rexp, vexp, pc;
  cmsc_events_t events, ev_cmd;
  cmsc_redirect_t vector_out, resume_out;
  logic [31:0] rq[$], vq[$], sp[7];
  logic [5:0] pev[3] = '{6'h34, 6'h38, 6'h30};
  logic [31:0] pvec[3] = '{32'h10, 32'h0C, 32'h04};
  logic [4:0] pmod[3] = '{5'h17, 5'h17, 5'h1B};
  int miscompares = 0;
  int num_checks = 0;
  int seed = 76;
  cmsc_core DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq_req(irq_req),
    .fiq_req(fiq_req), .events(events), .exec_pc(exec_pc), .sp_wr_en(sp_wr_en),
    .sp_wr_data(sp_wr_data), .cur_mode(cur_mode), .compact_state(compact_state),
    .privileged(privileged), .active_sp(active_sp), .vector_out(vector_out),
    .resume_out(resume_out));
  cmsc_partner u_far (.hclk(hclk), .hresetn(hresetn), .raise(raise), .clear(clear),
    .ev_cmd(ev_cmd), .irq_req(irq_req), .fiq_req(fiq_req), .events(events));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // ------------------------------------------------------------
  // monitor: oldest note against each result
  // ------------------------------------------------------------
  always @(posedge hclk) begin
    if (rd_dp) begin
      rexp = (rq.size() > 0) ? rq.pop_front() : 32'hDEAD_BEEF;
      `CHK("hrdata", rexp, hrdata)
      `CHK("hresp", 1'b0, hresp)
    end
    // entry and return redirects never overlap, so one ordered queue serves both
    if (vector_out.valid === 1'b1 || resume_out.valid === 1'b1) begin
      vexp = (vq.size() > 0) ? vq.pop_front() : 32'hDEAD_BEEF;
      `CHK("redirect", vexp, vector_out.valid ? vector_out.addr : resume_out.addr)
    end
    rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic ready_edge;
    int n;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin miscompares++; print_verdict; end
  endtask : ready_edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    ready_edge;
    htrans <= 2'h0;
    hwdata <= d;
    ready_edge;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  // polls off the edge, resumes on it so drives stay edge aligned
  task automatic settle(input logic [4:0] m, input logic c);
    int n;
    n = 0;
    while ((cur_mode !== m || compact_state !== c) && n < 20) begin @(negedge hclk); n++; end
    if (n >= 20) begin miscompares++; print_verdict; end
    @(posedge hclk);
  endtask : settle
  task automatic pulse(input logic [5:0] e, input logic [31:0] v, input logic [4:0] m,
      input logic c);
    if (v !== 32'hFFFF_FFFF) vq.push_back(v);
    ev_cmd <= cmsc_events_t'(e);
    @(posedge hclk);
    ev_cmd <= '0;
    settle(m, c);
  endtask : pulse
  task automatic req(input logic [1:0] r, input logic [1:0] k);
    raise <= r;
    clear <= k;
    @(posedge hclk);
    raise <= 2'h0;
    clear <= 2'h0;
  endtask : req
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, sp_wr_en} = '0;
    {htrans, raise, clear, haddr, hwdata, exec_pc, sp_wr_data} = '0;
    hsize = 3'h2;
    ev_cmd = '0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(8'h00, 32'hD3);
    rd(8'h18, 32'h0);
    $display("test reset finished");
    for (int i = 0; i < 7; i++) begin
      sp[i] = $random(seed);
      bus(1'b1, 8'h20 + 8'(4 * i), sp[i]);
    end
    rd(8'h0C, sp[3]);
    sp[3] = $random(seed);
    sp_wr_en <= 1'b1;
    sp_wr_data <= sp[3];
    @(posedge hclk);
    sp_wr_en <= 1'b0;
    rd(8'h0C, sp[3]);
    bus(1'b1, 8'h00, 32'hDF);
    settle(5'h1F, 1'b0);
    rd(8'h0C, sp[6]);
    bus(1'b1, 8'h00, 32'hD0);
    settle(5'h10, 1'b0);
    bus(1'b1, 8'h00, 32'hDF);
    rd(8'h00, 32'hD0);
    rd(8'h20, 32'h0);
    pc = $random(seed) & 32'hFFFF_FFFC;
    exec_pc <= pc;
    pulse(6'h20, 32'h08, 5'h13, 1'b0);
    rd(8'h04, 32'hD0);
    rd(8'h08, pc);
    rd(8'h0C, sp[3]);
    $display("test modes finished");
    for (int i = 0; i < 3; i++) pulse(pev[i], pvec[i], pmod[i], 1'b0);
    rd(8'h0C, sp[5]);
    bus(1'b1, 8'h00, 32'h5B);
    vq.push_back(32'h18);
    req(2'b01, 2'b00);
    settle(5'h12, 1'b0);
    rd(8'h00, 32'hD2);
    rd(8'h04, 32'h5B);
    bus(1'b1, 8'h00, 32'h92);
    vq.push_back(32'h1C);
    req(2'b10, 2'b00);
    settle(5'h11, 1'b0);
    `CHK("active_sp", sp[1], active_sp)
    rd(8'h00, 32'hD1);
    rd(8'h0C, sp[1]);
    rd(8'h08, pc);
    req(2'b00, 2'b10);
    // two edges for the cleared level to leave the synchroniser
    repeat (2) @(posedge hclk);
    vq.push_back(pc);
    bus(1'b1, 8'h10, 32'h1);
    settle(5'h12, 1'b0);
    rd(8'h00, 32'h92);
    $display("test interrupts finished");
    pulse(6'h03, 32'hFFFF_FFFF, 5'h12, 1'b1);
    rd(8'h00, 32'hB2);
    pulse(6'h20, 32'h08, 5'h13, 1'b1);
    rd(8'h00, 32'hB3);
    pulse(6'h02, 32'hFFFF_FFFF, 5'h13, 1'b0);
    req(2'b00, 2'b01);
    repeat (3) @(posedge hclk);
    `CHK("pending", 0, rq.size() + vq.size())
    $display("test state finished");
    print_verdict;
  end
endmodule : cmsc_tb_top
